// [hdl/tpp_top.sv]
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// - eight pins on ports A and B, six on port C, each independently configured
// - bit n of each port register controls pin n
// - direction 0: pin input, read returns pin
// - direction 1: pin output, high released unless push-pull, read returns latch
// - data writes always update the latch
// - output pins never request interrupts
// - group requests ORed, low pin masks others
// - two-bit polarity selects edge or level trigger
// - edge request latched, cleared on service entry
// - peripheral claim overrides port, drives pin, releases high if not push-pull
// - port A option: interrupt input, open drain
// - ports B, C option: pull-up, push-pull
// - all registers reset to zero
// - missing option bit: direction alone decides
module tpp_top
  import tpp_pkg::*;
#(
  parameter int PC_PINS = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port a pins
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pullup,
  // port b pins
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pullup,
  // port c pins
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  output logic [7:0] pc_pullup,
  // peripheral claims on port a
  input wire logic [7:0] pa_alt_en,
  input wire logic [7:0] pa_alt_out,
  input wire logic [7:0] pa_alt_pp,
  // peripheral claims on port b
  input wire logic [7:0] pb_alt_en,
  input wire logic [7:0] pb_alt_out,
  input wire logic [7:0] pb_alt_pp,
  // peripheral claims on port c
  input wire logic [7:0] pc_alt_en,
  input wire logic [7:0] pc_alt_out,
  input wire logic [7:0] pc_alt_pp,
  // external interrupt lines, group 0 port a, group 1 ports b and c
  input wire logic [1:0] irq_ack,
  output logic [1:0] ext_irq
);
  localparam logic [7:0] PC_MASK = 8'((1 << PC_PINS) - 1);

  typedef struct packed {
    logic [2:0][7:0] data;
    logic [2:0][7:0] dir;
    logic [2:0][7:0] opt;
    logic [1:0] g0_pol;
    logic [1:0] g1_pol;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0][7:0] out;
    logic [2:0][7:0] oe;
    logic [2:0][7:0] pull;
  } tpp_state_t;
  tpp_state_t q, d;

  logic [2:0][7:0] pin_s;
  logic [2:0][7:0] alt_en, alt_out, alt_pp;
  logic [2:0][7:0] irq_en;
  logic [1:0] grp_line;
  logic [5:0] idx;
  logic setup, access;

  assign alt_en = {pc_alt_en & PC_MASK, pb_alt_en, pa_alt_en};
  assign alt_out = {pc_alt_out, pb_alt_out, pa_alt_out};
  assign alt_pp = {pc_alt_pp, pb_alt_pp, pa_alt_pp};

  tpp_sync #(
    .W(24)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({pc_in & PC_MASK, pb_in, pa_in}),
    .q(pin_s)
  );

  // pad drive for one pin: {out, oe, pull}
  function automatic logic [2:0] pin_cfg(input int port, input logic dv, input logic dr,
                                          input logic op, input logic ae, input logic ao,
                                          input logic ap);
    logic pp;
    pp = op & (port != PORT_A);
    if (ae) begin
      pin_cfg = {ap & ao, ap | ~ao, 1'b0};
    end else if (dr) begin
      // port a option 1 is reserved and falls back to open drain
      pin_cfg = {pp & dv, pp | ~dv, 1'b0};
    end else begin
      pin_cfg = {2'b00, pp};
    end
  endfunction

  // data read: latch for outputs, synchronised pin for inputs
  function automatic logic [7:0] data_rd(input logic [7:0] dv, input logic [7:0] dr,
                                         input logic [7:0] ps);
    data_rd = (dr & dv) | (~dr & ps);
  endfunction

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      // outputs and claimed pins are kept out of the group
      irq_en[p] = ~q.dir[p] & q.opt[p] & ~alt_en[p];
    end
    // a low on any enabled pin pulls the group line low
    grp_line[0] = &(pin_s[PORT_A] | ~irq_en[PORT_A]);
    grp_line[1] = &(pin_s[PORT_B] | ~irq_en[PORT_B])
                & &(pin_s[PORT_C] | ~irq_en[PORT_C]);
  end

  assign idx = paddr[7:2];
  assign setup = psel & ~penable;
  assign access = psel & penable & q.pready;

  always_comb begin
    logic [2:0] cfg;
    cfg = 3'b000;
    d = q;
    d.pready = setup;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (setup) begin
      unique case (idx)
        IDX_PA_DATA: d.prdata[7:0] = data_rd(q.data[PORT_A], q.dir[PORT_A], pin_s[PORT_A]);
        IDX_PA_DIR: d.prdata[7:0] = q.dir[PORT_A];
        IDX_PA_OPT: d.prdata[7:0] = q.opt[PORT_A];
        IDX_PB_DATA: d.prdata[7:0] = data_rd(q.data[PORT_B], q.dir[PORT_B], pin_s[PORT_B]);
        IDX_PB_DIR: d.prdata[7:0] = q.dir[PORT_B];
        IDX_PB_OPT: d.prdata[7:0] = q.opt[PORT_B];
        IDX_PC_DATA: d.prdata[7:0] = data_rd(q.data[PORT_C], q.dir[PORT_C], pin_s[PORT_C]);
        IDX_PC_DIR: d.prdata[7:0] = q.dir[PORT_C];
        IDX_PC_OPT: d.prdata[7:0] = q.opt[PORT_C];
        IDX_POLARITY: begin
          d.prdata[G1_POL_LSB +: 2] = q.g1_pol;
          d.prdata[G0_POL_LSB +: 2] = q.g0_pol;
        end
        default: d.pslverr = 1'b1;
      endcase
    end else if (access) begin
      d.pslverr = 1'b0;
      d.pready = 1'b0;
    end
    if (access && pwrite) begin
      unique case (idx)
        IDX_PA_DATA: d.data[PORT_A] = pwdata[7:0];
        IDX_PA_DIR: d.dir[PORT_A] = pwdata[7:0];
        IDX_PA_OPT: d.opt[PORT_A] = pwdata[7:0];
        IDX_PB_DATA: d.data[PORT_B] = pwdata[7:0];
        IDX_PB_DIR: d.dir[PORT_B] = pwdata[7:0];
        IDX_PB_OPT: d.opt[PORT_B] = pwdata[7:0];
        IDX_PC_DATA: d.data[PORT_C] = pwdata[7:0] & PC_MASK;
        IDX_PC_DIR: d.dir[PORT_C] = pwdata[7:0] & PC_MASK;
        IDX_PC_OPT: d.opt[PORT_C] = pwdata[7:0] & PC_MASK;
        IDX_POLARITY: begin
          d.g1_pol = pwdata[G1_POL_LSB +: 2];
          d.g0_pol = pwdata[G0_POL_LSB +: 2];
        end
        default: d.g0_pol = q.g0_pol;
      endcase
    end
    // pad outputs are registered, so they trail the registers by one cycle
    for (int p = 0; p < 3; p++) begin
      for (int b = 0; b < 8; b++) begin
        cfg = pin_cfg(p, q.data[p][b], q.dir[p][b], q.opt[p][b],
                      alt_en[p][b], alt_out[p][b], alt_pp[p][b]);
        d.out[p][b] = cfg[2];
        d.oe[p][b] = cfg[1];
        d.pull[p][b] = cfg[0];
      end
    end
    d.out[PORT_C] = d.out[PORT_C] & PC_MASK;
    d.oe[PORT_C] = d.oe[PORT_C] & PC_MASK;
    d.pull[PORT_C] = d.pull[PORT_C] & PC_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.data <= {3{REG_RST}};
      q.dir <= {3{REG_RST}};
      q.opt <= {3{REG_RST}};
      q.g0_pol <= POL_RST;
      q.g1_pol <= POL_RST;
      q.prdata <= '0;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
      q.out <= '0;
      q.oe <= '0;
      q.pull <= '0;
    end else begin
      q <= d;
    end
  end

  tpp_irq_group u_irq0 (
    .pclk(pclk),
    .presetn(presetn),
    .line(grp_line[0]),
    .pol(q.g0_pol),
    .ack(irq_ack[0]),
    .irq(ext_irq[0])
  );

  tpp_irq_group u_irq1 (
    .pclk(pclk),
    .presetn(presetn),
    .line(grp_line[1]),
    .pol(q.g1_pol),
    .ack(irq_ack[1]),
    .irq(ext_irq[1])
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign pa_out = q.out[PORT_A];
  assign pa_oe = q.oe[PORT_A];
  assign pa_pullup = q.pull[PORT_A];
  assign pb_out = q.out[PORT_B];
  assign pb_oe = q.oe[PORT_B];
  assign pb_pullup = q.pull[PORT_B];
  assign pc_out = q.out[PORT_C];
  assign pc_oe = q.oe[PORT_C];
  assign pc_pullup = q.pull[PORT_C];

  rd_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && idx == IDX_PA_DATA) |=>
      prdata[7:0] == (($past(q.dir[PORT_A]) & $past(q.data[PORT_A]))
                     | (~$past(q.dir[PORT_A]) & $past(pin_s[PORT_A]))))
    else $error("port a data read wrong");
  wr_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && idx == IDX_PB_DATA) |=> q.data[PORT_B] == $past(pwdata[7:0]))
    else $error("data latch not written");
  out_noirq_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((q.dir[PORT_A] | ~q.opt[PORT_A] | pin_s[PORT_A]) == 8'hFF) |-> grp_line[0])
    else $error("output pin requested interrupt");
  or_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(irq_en[PORT_B] & ~pin_s[PORT_B])) |-> !grp_line[1])
    else $error("low pin did not mask group");
  alt_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pa_alt_en[0] && pa_alt_pp[0]) |=> pa_oe[0] && pa_out[0] == $past(pa_alt_out[0]))
    else $error("alternate function did not drive");
  pa_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!pa_alt_en[1] && q.dir[PORT_A][1] && q.data[PORT_A][1]) |=> !pa_oe[1] && !pa_pullup[1])
    else $error("port a high not released");
  pb_push_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!pb_alt_en[2] && q.dir[PORT_B][2] && q.opt[PORT_B][2]) |=>
      pb_oe[2] && pb_out[2] == $past(q.data[PORT_B][2]))
    else $error("push-pull not driven");
  rst_zero_a: assert property (@(posedge pclk)
    $rose(presetn) |-> (q.data == '0 && q.dir == '0 && q.opt == '0 && ext_irq == 2'b00))
    else $error("registers not zero after reset");

  // read path
  rd_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && idx == IDX_PC_DATA && !q.dir[PORT_C][0]) |=>
      prdata[0] == $past(pin_s[PORT_C][0])) else $error("input read not pin level");
  rd_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && idx == IDX_PB_DATA && q.dir[PORT_B][3]) |=>
      prdata[3] == $past(q.data[PORT_B][3])) else $error("output read not latch");
  bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && idx == 6'h03) |=> (pready && pslverr && prdata == 32'h0))
    else $error("unmapped index not refused");

  // write path
  wr_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && idx == IDX_PA_DIR) |=> q.dir[PORT_A] == $past(pwdata[7:0]))
    else $error("direction not written");
  wr_opt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && idx == IDX_PC_OPT) |=>
      q.opt[PORT_C] == ($past(pwdata[7:0]) & PC_MASK)) else $error("option not written");
  wr_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && idx == IDX_PC_DATA) |=>
      q.data[PORT_C] == ($past(pwdata[7:0]) & PC_MASK)) else $error("latch not written");
  pol_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && idx == IDX_POLARITY) |=>
      (q.g1_pol == $past(pwdata[G1_POL_LSB +: 2])
       && q.g0_pol == $past(pwdata[G0_POL_LSB +: 2])))
    else $error("polarity not written");

  // pad drive
  pa_sink_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!pa_alt_en[2] && q.dir[PORT_A][2] && !q.data[PORT_A][2]) |=> pa_oe[2] && !pa_out[2])
    else $error("port a low not sunk");
  pa_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!pa_alt_en[3] && !q.dir[PORT_A][3]) |=> !pa_oe[3] && !pa_pullup[3])
    else $error("port a input not floating");
  pb_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!pb_alt_en[4] && !q.dir[PORT_B][4] && !q.opt[PORT_B][4]) |=> !pb_oe[4] && !pb_pullup[4])
    else $error("floating input driven");
  pc_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!pc_alt_en[1] && !q.dir[PORT_C][1] && q.opt[PORT_C][1]) |=> pc_pullup[1] && !pc_oe[1])
    else $error("interrupt input without pull-up");
  pc_unused_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pc_oe[7:6] == 2'b00 && pc_pullup[7:6] == 2'b00 && q.data[PORT_C][7:6] == 2'b00))
    else $error("missing port c pins active");
  alt_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pb_alt_en[5] && !pb_alt_pp[5]) |=> (pb_oe[5] == !$past(pb_alt_out[5]) && !pb_out[5]))
    else $error("alternate open drain wrong");
  alt_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pc_alt_en[2] && pc_alt_pp[2]) |=> pc_oe[2] && pc_out[2] == $past(pc_alt_out[2]))
    else $error("port c alternate did not drive");

  // interrupt grouping, pads after reset
  grp_c_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(irq_en[PORT_C] & ~pin_s[PORT_C])) |-> !grp_line[1])
    else $error("port c pin did not mask group");
  rst_pad_a: assert property (@(posedge pclk)
    $rose(presetn) |-> ({pa_oe, pb_oe, pc_oe, pb_pullup, pc_pullup} == 40'h0))
    else $error("pads active after reset");

  wr_cov: cover property (@(posedge pclk) disable iff (!presetn) access && pwrite);
  rd_cov: cover property (@(posedge pclk) disable iff (!presetn) access && !pwrite);
  err_cov: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
  irq_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(ext_irq[1]));
  lvl_cov: cover property (@(posedge pclk) disable iff (!presetn)
    ext_irq[0] && q.g0_pol == POL_LOW_FALL);
endmodule

// [hdl/tpp_pkg.sv]
package tpp_pkg;
  // register index; byte address is four times the index
  localparam logic [5:0] IDX_PC_DATA = 6'h00;
  localparam logic [5:0] IDX_PC_DIR = 6'h01;
  localparam logic [5:0] IDX_PC_OPT = 6'h02;
  localparam logic [5:0] IDX_PB_DATA = 6'h04;
  localparam logic [5:0] IDX_PB_DIR = 6'h05;
  localparam logic [5:0] IDX_PB_OPT = 6'h06;
  localparam logic [5:0] IDX_PA_DATA = 6'h08;
  localparam logic [5:0] IDX_PA_DIR = 6'h09;
  localparam logic [5:0] IDX_PA_OPT = 6'h0A;
  localparam logic [5:0] IDX_POLARITY = 6'h0C;
  // field positions in the polarity register
  localparam int G1_POL_LSB = 6;
  localparam int G0_POL_LSB = 3;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] POL_RST = 2'h0;
  // port numbers inside the packed arrays
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  typedef enum logic [1:0] {
    POL_LOW_FALL = 2'h0,
    POL_RISE = 2'h1,
    POL_FALL = 2'h2,
    POL_BOTH = 2'h3
  } tpp_pol_t;
endpackage

// [hdl/tpp_sync.sv]
`timescale 1ns/10ps
module tpp_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tpp_sync_t;
  tpp_sync_t r_q, r_d;

  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;

  sync_stage_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_q.s2 == $past(d, 2)) else $error("synchroniser depth wrong");
endmodule

// [hdl/tpp_irq_group.sv]
`timescale 1ns/10ps
module tpp_irq_group
  import tpp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // combined group line, active low
  input wire logic line,
  input wire logic [1:0] pol,
  input wire logic ack,
  // request
  output logic irq
);
  typedef struct packed {
    logic prev;
    logic latch;
    logic irq;
  } tpp_irq_t;
  tpp_irq_t r_q, r_d;
  logic fall, rise, set;

  always_comb begin
    fall = r_q.prev & ~line;
    rise = ~r_q.prev & line;
    unique case (tpp_pol_t'(pol))
      POL_LOW_FALL: set = fall;
      POL_FALL: set = fall;
      POL_RISE: set = rise;
      POL_BOTH: set = fall | rise;
    endcase
    r_d.prev = line;
    // set wins over an acknowledge in the same cycle
    r_d.latch = set | (r_q.latch & ~ack);
    r_d.irq = r_d.latch | (tpp_pol_t'(pol) == POL_LOW_FALL & ~line);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= 3'b100;
    end else begin
      r_q <= r_d;
    end
  end

  assign irq = r_q.irq;

  rise_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pol == POL_RISE && !r_q.prev && line) |=> (r_q.latch && irq))
    else $error("rising edge not latched");
  ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ack && !set && pol != POL_LOW_FALL) |=> !irq)
    else $error("acknowledge did not clear request");
  low_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pol == POL_LOW_FALL && !line) |=> irq) else $error("low level not requested");
endmodule

// [testbench/tpp_board.sv]
`timescale 1ns/10ps
module tpp_board (
  // pad side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  // board drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_lvl,
  // resolved level
  output logic [7:0] pin
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pin[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_lvl[i];
      end else if (pad_pullup[i]) begin
        pin[i] = 1'b1;
      end else begin
        // nothing drives: no stale level survives
        pin[i] = ~ext_lvl[i];
      end
    end
  end
endmodule

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
  import tpp_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [1:0] irq_ack = 2'h0, ext_irq;
  logic [7:0] pin [3], brd [3], ben [3], pout [3], poe [3], ppu [3], aen [3], aout [3], app [3];
  logic [7:0] dat [3], dir [3], opt [3];
  logic [7:0] dadr [3] = '{8'h20, 8'h10, 8'h00};
  int fails = 0, n_checks = 0;
  genvar g;
  always #10 pclk = ~pclk;
  tpp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pa_in(pin[0]), .pa_out(pout[0]), .pa_oe(poe[0]), .pa_pullup(ppu[0]),
    .pb_in(pin[1]), .pb_out(pout[1]), .pb_oe(poe[1]), .pb_pullup(ppu[1]),
    .pc_in(pin[2]), .pc_out(pout[2]), .pc_oe(poe[2]), .pc_pullup(ppu[2]),
    .pa_alt_en(aen[0]), .pa_alt_out(aout[0]), .pa_alt_pp(app[0]),
    .pb_alt_en(aen[1]), .pb_alt_out(aout[1]), .pb_alt_pp(app[1]),
    .pc_alt_en(aen[2]), .pc_alt_out(aout[2]), .pc_alt_pp(app[2]),
    .irq_ack(irq_ack), .ext_irq(ext_irq));
  for (g = 0; g < 3; g++) begin : bd
    tpp_board brd_u (.pad_out(pout[g]), .pad_oe(poe[g]), .pad_pullup(ppu[g]),
      .ext_en(ben[g]), .ext_lvl(brd[g]), .pin(pin[g]));
  end
  function automatic logic [7:0] msk(int p);
    return (p == PORT_C) ? 8'h3F : 8'hFF;
  endfunction
  function automatic logic [7:0] m_oe(int p);
    logic [7:0] pp;
    pp = (p == PORT_A) ? 8'h00 : opt[p];
    return msk(p) & ((aen[p] & (app[p] | ~aout[p])) | (~aen[p] & dir[p] & (pp | ~dat[p])));
  endfunction
  function automatic logic [7:0] m_drv(int p);
    logic [7:0] pp;
    pp = (p == PORT_A) ? 8'h00 : opt[p];
    return m_oe(p) & ((aen[p] & aout[p]) | (~aen[p] & pp & dat[p]));
  endfunction
  function automatic logic [7:0] m_pu(int p);
    return (p == PORT_A) ? 8'h00 : msk(p) & ~dir[p] & opt[p] & ~aen[p];
  endfunction
  function automatic logic [7:0] m_rd(int p);
    logic [7:0] fl, lv;
    fl = (ben[p] & brd[p]) | (~ben[p] & (m_pu(p) | ~brd[p]));
    lv = (m_oe(p) & m_drv(p)) | (~m_oe(p) & fl);
    return msk(p) & ((dir[p] & dat[p]) | (~dir[p] & lv));
  endfunction
  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20) begin
      fails++;
      conclude();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(rv, {24'h0, x});
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic ack(input int gi);
    irq_ack[gi] <= 1'b1;
    @(posedge pclk);
    irq_ack[gi] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    void'($urandom(25));
    for (int p = 0; p < 3; p++) begin
      brd[p] = 8'h00;
      ben[p] = 8'hFF;
      {aen[p], aout[p], app[p], dat[p], dir[p], opt[p]} = '0;
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int p = 0; p < 3; p++) begin
      rdc(dadr[p], m_rd(p));
      rdc(dadr[p] + 8'h04, 8'h00);
      rdc(dadr[p] + 8'h08, 8'h00);
      chk({poe[p], ppu[p]}, 32'h0);
    end
    apb(1'b1, 8'h0C, 8'hA5);
    apb(1'b0, 8'h0C, 8'h00);
    chk({rv[30:0], e}, 32'h1);
    for (int i = 0; i < 60; i++) begin
      int p;
      p = $urandom_range(2);
      dat[p] = 8'($urandom);
      dir[p] = 8'($urandom);
      opt[p] = 8'($urandom);
      aen[p] <= 8'h00;
      brd[p] <= 8'($urandom);
      ben[p] <= 8'($urandom) | 8'h0F;
      apb(1'b1, dadr[p], dat[p]);
      apb(1'b1, dadr[p] + 8'h04, dir[p]);
      apb(1'b1, dadr[p] + 8'h08, opt[p]);
      // peripherals claim only plain floating inputs, once reconfigured
      aen[p] <= msk(p) & ~dir[p] & ~opt[p] & 8'($urandom);
      aout[p] <= 8'($urandom);
      app[p] <= 8'($urandom);
      repeat (4) @(posedge pclk);
      for (int q = 0; q < 3; q++) begin
        chk(poe[q], m_oe(q));
        chk(poe[q] & pout[q], m_drv(q));
        chk(ppu[q], m_pu(q));
        rdc(dadr[q], m_rd(q));
        rdc(dadr[q] + 8'h04, msk(q) & dir[q]);
        rdc(dadr[q] + 8'h08, msk(q) & opt[q]);
      end
    end
    for (int p = 0; p < 3; p++) begin
      aen[p] <= 8'h00;
      ben[p] <= 8'hFF;
      brd[p] <= 8'hFF;
      for (int r = 0; r < 3; r++) apb(1'b1, dadr[p] + 8'(4 * r), 8'h00);
    end
    for (int gi = 0; gi < 2; gi++) begin
      int pt;
      pt = gi ? PORT_B : PORT_A;
      apb(1'b1, dadr[pt] + 8'h08, 8'h01);
      for (int pc = 0; pc < 4; pc++) begin
        apb(1'b1, 8'h30, 8'(pc << (gi ? G1_POL_LSB : G0_POL_LSB)));
        ack(gi);
        chk(ext_irq[gi], 32'h0);
        brd[pt] <= 8'hFE;
        repeat (6) @(posedge pclk);
        chk(ext_irq[gi], pc != 1);
        ack(gi);
        chk(ext_irq[gi], pc == 0);
        brd[pt] <= 8'hFF;
        repeat (6) @(posedge pclk);
        chk(ext_irq[gi], pc % 2);
        ack(gi);
      end
      apb(1'b1, dadr[pt] + 8'h08, 8'h00);
    end
    apb(1'b1, 8'h30, 8'(2 << G0_POL_LSB));
    apb(1'b1, 8'h28, 8'h03);
    brd[0] <= 8'hFD;
    repeat (6) @(posedge pclk);
    ack(0);
    brd[0] <= 8'hFC;
    repeat (6) @(posedge pclk);
    chk(ext_irq[0], 32'h0);
    brd[0] <= 8'hFF;
    apb(1'b1, 8'h28, 8'h01);
    repeat (6) @(posedge pclk);
    ack(0);
    // pin 0 turns output and its latch 0 pulls the pad low
    apb(1'b1, 8'h24, 8'h01);
    repeat (6) @(posedge pclk);
    chk(ext_irq[0], 32'h0);
    conclude();
  end
endmodule
